// [logic/ssfs_defs.svh]
// constants of the status output function selector: register map, option codes, flag positions, timing
// assumes a 25 MHz system clock and an 8-bit byte-addressed APB window
`ifndef SSFS_DEFS_SVH
`define SSFS_DEFS_SVH

// register byte offsets
`define SSFS_REG_TERM_SEL   8'h00
`define SSFS_REG_FB_LOW     8'h04
`define SSFS_REG_FB_HIGH    8'h08
`define SSFS_REG_WD_PERIOD  8'h0C
`define SSFS_REG_HEAT_THR   8'h10
`define SSFS_REG_LOAD_LVL   8'h14
`define SSFS_REG_LOGIC_A    8'h18
`define SSFS_REG_LOGIC_B    8'h1C
`define SSFS_REG_LOGIC_C    8'h20
`define SSFS_REG_GPO        8'h24
`define SSFS_REG_FLAGS      8'h28
`define SSFS_REG_IRQ_ST     8'h2C
`define SSFS_REG_IRQ_MASK   8'h30

// option codes
`define SSFS_OPT_FB2        8'h1F
`define SSFS_OPT_NET        8'h20
`define SSFS_OPT_LOG_A      8'h21
`define SSFS_OPT_LOG_B      8'h22
`define SSFS_OPT_LOG_C      8'h23
`define SSFS_OPT_CAP        8'h27
`define SSFS_OPT_FAN        8'h28
`define SSFS_OPT_START      8'h29
`define SSFS_OPT_HEAT       8'h2A
`define SSFS_OPT_LOAD       8'h2B
`define SSFS_OPT_MO_A       8'h2C
`define SSFS_OPT_MO_B       8'h2D
`define SSFS_OPT_NONE       8'hFF

// flag vector positions
`define SSFS_F_FB2          0
`define SSFS_F_NET          1
`define SSFS_F_LOG_A        2
`define SSFS_F_LOG_B        3
`define SSFS_F_LOG_C        4
`define SSFS_F_CAP          5
`define SSFS_F_FAN          6
`define SSFS_F_START        7
`define SSFS_F_HEAT         8
`define SSFS_F_LOAD         9
`define SSFS_F_MO_A         10
`define SSFS_F_MO_B         11
`define SSFS_NUM_FLAGS      12

// synchronised pin positions
`define SSFS_P_RUN          0
`define SSFS_P_FWD          1
`define SSFS_P_REV          2
`define SSFS_P_CAP          3
`define SSFS_P_FAN          4
`define SSFS_P_COMM         5

// logic function config fields and operators
`define SSFS_LC_SRC_A       3:0
`define SSFS_LC_SRC_B       7:4
`define SSFS_LC_OP          9:8
`define SSFS_OP_AND         2'h0
`define SSFS_OP_OR          2'h1
`define SSFS_OP_XOR         2'h2
`define SSFS_OP_NAND        2'h3

// reset values
`define SSFS_RST_TERM_SEL   32'hFFFFFFFF
`define SSFS_RST_VAL        16'h0000
`define SSFS_RST_LOGIC      10'h000

// timing: watchdog tick is one millisecond
`define SSFS_CLK_NS         40
`define SSFS_WD_TICK_NS     1000000
`define SSFS_WD_TICK_CYC    (`SSFS_WD_TICK_NS / `SSFS_CLK_NS)

`endif

// [logic/ssfs_pkg.sv]
// types of the status output function selector
// flag vector widths come from ssfs_defs.svh
`default_nettype none
`include "ssfs_defs.svh"

package ssfs_pkg;

  // state of the selector core
  typedef struct packed {
    logic [31:0]                     sel;
    logic [15:0]                     fb_low;
    logic [15:0]                     fb_high;
    logic [15:0]                     wd_period;
    logic [15:0]                     heat_thr;
    logic [15:0]                     load_lvl;
    logic [2:0][9:0]                 lcfg;
    logic [1:0]                      gpo;
    logic [`SSFS_NUM_FLAGS-1:0]      flags;
    logic [`SSFS_NUM_FLAGS-1:0]      irq_st;
    logic [`SSFS_NUM_FLAGS-1:0]      irq_mask;
    logic [5:0]                      sync1;
    logic [5:0]                      sync2;
    logic                            run_d;
    logic                            comm_d;
    logic [15:0]                     tick_cnt;
    logic [15:0]                     wd_cnt;
    logic                            pready;
    logic                            pslverr;
    logic [31:0]                     prdata;
    logic                            irq;
  } ssfs_state_s;

  // state of one terminal multiplexer
  typedef struct packed {
    logic out;
  } ssfs_mux_s;

endpackage
`default_nettype wire

// [logic/ssfs_term_mux.sv]
// one output terminal: routes the flag of the selected option code to a registered pin
// assumes flags and code come from logic on clk_sys
`timescale 1ns/1ps
`default_nettype none
`include "ssfs_defs.svh"

module ssfs_term_mux
  import ssfs_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_n,
  // selection
  input  wire logic [7:0]                 code,
  input  wire logic [`SSFS_NUM_FLAGS-1:0] flags,
  // terminal
  output logic                            term_out
);

  ssfs_mux_s s;
  ssfs_mux_s n;

  // pick the flag for the code, unknown codes give low
  always_comb
  begin
    n = s;
    case (code)
      `SSFS_OPT_FB2:   n.out = flags[`SSFS_F_FB2];
      `SSFS_OPT_NET:   n.out = flags[`SSFS_F_NET];
      `SSFS_OPT_LOG_A: n.out = flags[`SSFS_F_LOG_A];
      `SSFS_OPT_LOG_B: n.out = flags[`SSFS_F_LOG_B];
      `SSFS_OPT_LOG_C: n.out = flags[`SSFS_F_LOG_C];
      `SSFS_OPT_CAP:   n.out = flags[`SSFS_F_CAP];
      `SSFS_OPT_FAN:   n.out = flags[`SSFS_F_FAN];
      `SSFS_OPT_START: n.out = flags[`SSFS_F_START];
      `SSFS_OPT_HEAT:  n.out = flags[`SSFS_F_HEAT];
      `SSFS_OPT_LOAD:  n.out = flags[`SSFS_F_LOAD];
      `SSFS_OPT_MO_A: n.out = flags[`SSFS_F_MO_A];
      `SSFS_OPT_MO_B: n.out = flags[`SSFS_F_MO_B];
      default:        n.out = 1'b0;
    endcase
  end

  // register the terminal
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      s <= '0;
    else
      s <= n;
  end

  assign term_out = s.out;

  // a selected general output reaches the pin one cycle later
  a_term_route_gpo: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (code == `SSFS_OPT_MO_A) |=> (term_out == $past(flags[`SSFS_F_MO_A])))
    else $error("terminal does not follow general output a");

  // an unknown code keeps the pin low
  a_term_route_none: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (code == `SSFS_OPT_NONE) |=> !term_out)
    else $error("terminal high with no function selected");

endmodule
`default_nettype wire

// [logic/ssfs_top.sv]
// status output function selector: computes drive status flags and routes them to output terminals
// assumes an APB master on clk_sys; drive pins are asynchronous; measured values come from clk_sys logic
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ssfs_defs.svh"

module ssfs_top
  import ssfs_pkg::*;
#(
  parameter int          NUM_TERM    = 2,
  parameter logic [15:0] WD_TICK_CYC = 16'(`SSFS_WD_TICK_CYC)
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // apb slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  // drive pins, asynchronous
  input  wire logic                run_state_in,
  input  wire logic                forward_run_command,
  input  wire logic                reverse_run_command,
  input  wire logic                capacitor_life_expired,
  input  wire logic                cooling_fan_life_expired,
  input  wire logic                comm_activity,
  // measured values, on clk_sys
  input  wire logic [15:0]         process_feedback_value,
  input  wire logic [15:0]         heatsink_temp,
  input  wire logic [15:0]         motor_current,
  // terminals and interrupt
  output logic [NUM_TERM-1:0]      term_out,
  output logic                     irq
);

  ssfs_state_s s;
  ssfs_state_s n;

  // decoded helpers
  logic                         run;
  logic                         comm_pulse;
  logic                         tick;
  logic                         setup;
  logic                         access_w;
  logic                         access_r;
  logic                         mapped;
  logic [31:0]                  rd_word;
  logic [`SSFS_NUM_FLAGS-1:0]   rise;
  logic [`SSFS_NUM_FLAGS-1:0]   clr;

  assign run        = s.sync2[`SSFS_P_RUN];
  assign comm_pulse = s.sync2[`SSFS_P_COMM] & ~s.comm_d;
  assign tick       = (s.tick_cnt == WD_TICK_CYC - 16'h0001);
  assign setup      = psel & ~penable;
  assign access_w   = psel & penable & s.pready & pwrite;
  assign access_r   = psel & penable & s.pready & ~pwrite;

  // result of one configurable Boolean function over the previous flags
  function automatic logic logic_eval(input logic [9:0] cfg, input logic [`SSFS_NUM_FLAGS-1:0] f);
    logic a;
    logic b;
    logic r;
    a = (cfg[`SSFS_LC_SRC_A] < 4'(`SSFS_NUM_FLAGS)) ? f[cfg[`SSFS_LC_SRC_A]] : 1'b0;
    b = (cfg[`SSFS_LC_SRC_B] < 4'(`SSFS_NUM_FLAGS)) ? f[cfg[`SSFS_LC_SRC_B]] : 1'b0;
    case (cfg[`SSFS_LC_OP])
      `SSFS_OP_AND: r = a & b;
      `SSFS_OP_OR:  r = a | b;
      `SSFS_OP_XOR: r = a ^ b;
      default:      r = ~(a & b);
    endcase
    return r;
  endfunction

  // read mux and address decode
  always_comb
  begin
    rd_word = 32'h00000000;
    mapped  = 1'b1;
    case (paddr)
      `SSFS_REG_TERM_SEL:  rd_word = s.sel;
      `SSFS_REG_FB_LOW:    rd_word = {16'h0000, s.fb_low};
      `SSFS_REG_FB_HIGH:   rd_word = {16'h0000, s.fb_high};
      `SSFS_REG_WD_PERIOD: rd_word = {16'h0000, s.wd_period};
      `SSFS_REG_HEAT_THR:  rd_word = {16'h0000, s.heat_thr};
      `SSFS_REG_LOAD_LVL:  rd_word = {16'h0000, s.load_lvl};
      `SSFS_REG_LOGIC_A:   rd_word = {22'h000000, s.lcfg[0]};
      `SSFS_REG_LOGIC_B:   rd_word = {22'h000000, s.lcfg[1]};
      `SSFS_REG_LOGIC_C:   rd_word = {22'h000000, s.lcfg[2]};
      `SSFS_REG_GPO:       rd_word = {30'h00000000, s.gpo};
      `SSFS_REG_FLAGS:     rd_word = {20'h00000, s.flags};
      `SSFS_REG_IRQ_ST:    rd_word = {20'h00000, s.irq_st};
      `SSFS_REG_IRQ_MASK:  rd_word = {20'h00000, s.irq_mask};
      default:             mapped  = 1'b0;
    endcase
  end

  // next state of the whole core
  always_comb
  begin
    n = s;
    rise = '0;
    clr  = '0;
    // two-stage synchronisers for the drive pins
    n.sync1  = {comm_activity, cooling_fan_life_expired, capacitor_life_expired,
                reverse_run_command, forward_run_command, run_state_in};
    n.sync2  = s.sync1;
    n.run_d  = run;
    n.comm_d = s.sync2[`SSFS_P_COMM];
    // millisecond tick for the watchdog
    n.tick_cnt = tick ? 16'h0000 : 16'(s.tick_cnt + 16'h0001);
    // watchdog restarts on traffic, counts up to the period and holds there
    if (comm_pulse)
      n.wd_cnt = 16'h0000;
    else if (tick && (s.wd_period != 16'h0000) && (s.wd_cnt < s.wd_period))
      n.wd_cnt = 16'(s.wd_cnt + 16'h0001);
    n.flags[`SSFS_F_NET] = !comm_pulse && (s.wd_period != 16'h0000)
                           && (n.wd_cnt >= s.wd_period);
    // feedback second stage: clear has priority over set
    if ((process_feedback_value > s.fb_high) || (s.run_d && !run))
      n.flags[`SSFS_F_FB2] = 1'b0;
    else if (run && (process_feedback_value < s.fb_low))
      n.flags[`SSFS_F_FB2] = 1'b1;
    // logic functions
    n.flags[`SSFS_F_LOG_A] = logic_eval(s.lcfg[0], s.flags);
    n.flags[`SSFS_F_LOG_B] = logic_eval(s.lcfg[1], s.flags);
    n.flags[`SSFS_F_LOG_C] = logic_eval(s.lcfg[2], s.flags);
    // level flags re-evaluated every cycle
    n.flags[`SSFS_F_CAP]   = s.sync2[`SSFS_P_CAP];
    n.flags[`SSFS_F_FAN]   = s.sync2[`SSFS_P_FAN];
    n.flags[`SSFS_F_START] = s.sync2[`SSFS_P_FWD] ^ s.sync2[`SSFS_P_REV];
    n.flags[`SSFS_F_HEAT]  = heatsink_temp > s.heat_thr;
    n.flags[`SSFS_F_LOAD]  = motor_current < s.load_lvl;
    n.flags[`SSFS_F_MO_A] = s.gpo[0];
    n.flags[`SSFS_F_MO_B] = s.gpo[1];
    // apb: answer in the first access cycle
    n.pready  = setup;
    n.pslverr = setup & ~mapped;
    if (setup)
      n.prdata = rd_word;
    if (access_w && mapped)
    begin
      case (paddr)
        `SSFS_REG_TERM_SEL:  n.sel       = pwdata;
        `SSFS_REG_FB_LOW:    n.fb_low    = pwdata[15:0];
        `SSFS_REG_FB_HIGH:   n.fb_high   = pwdata[15:0];
        `SSFS_REG_WD_PERIOD: n.wd_period = pwdata[15:0];
        `SSFS_REG_HEAT_THR:  n.heat_thr  = pwdata[15:0];
        `SSFS_REG_LOAD_LVL:  n.load_lvl  = pwdata[15:0];
        `SSFS_REG_LOGIC_A:   n.lcfg[0]   = pwdata[9:0];
        `SSFS_REG_LOGIC_B:   n.lcfg[1]   = pwdata[9:0];
        `SSFS_REG_LOGIC_C:   n.lcfg[2]   = pwdata[9:0];
        `SSFS_REG_GPO:       n.gpo       = pwdata[1:0];
        `SSFS_REG_IRQ_MASK:  n.irq_mask  = pwdata[`SSFS_NUM_FLAGS-1:0];
        default:             n.gpo       = s.gpo;
      endcase
    end
    // a read of the status clears only the bits it returned; new rises win
    if (access_r && (paddr == `SSFS_REG_IRQ_ST))
      clr = s.prdata[`SSFS_NUM_FLAGS-1:0];
    rise     = n.flags & ~s.flags;
    n.irq_st = (s.irq_st & ~clr) | rise;
    n.irq    = |(n.irq_st & n.irq_mask);
  end

  // register the state
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s           <= '0;
      s.sel       <= `SSFS_RST_TERM_SEL;
      s.fb_low    <= `SSFS_RST_VAL;
      s.fb_high   <= `SSFS_RST_VAL;
      s.wd_period <= `SSFS_RST_VAL;
      s.heat_thr  <= `SSFS_RST_VAL;
      s.load_lvl  <= `SSFS_RST_VAL;
      s.lcfg      <= {3{`SSFS_RST_LOGIC}};
    end
    else
      s <= n;
  end

  // one multiplexer per terminal
  genvar gi;
  generate
    for (gi = 0; gi < NUM_TERM; gi++)
    begin : g_term
      ssfs_term_mux i_ssfs_term_mux (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .code     (s.sel[8*gi +: 8]),
        .flags    (s.flags),
        .term_out (term_out[gi])
      );
    end
  endgenerate

  // outputs straight from flip-flops
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign irq     = s.irq;

  // feedback flag sets while running below the low limit
  a_fb2_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (run && s.run_d && (process_feedback_value < s.fb_low) && !(process_feedback_value > s.fb_high))
    |=> s.flags[`SSFS_F_FB2])
    else $error("feedback flag did not set");

  // feedback flag clears above the high limit or on stop
  a_fb2_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((process_feedback_value > s.fb_high) || (s.run_d && !run)) |=> !s.flags[`SSFS_F_FB2])
    else $error("feedback flag did not clear");

  // while the drive stays stopped the feedback flag cannot come back
  a_fb2_stopped: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!run && !s.run_d) |=> !s.flags[`SSFS_F_FB2])
    else $error("feedback flag set while the drive is stopped");

  // watchdog expiry sets the network flag, traffic clears it
  a_net_expire: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((s.wd_period != 16'h0000) && (s.wd_cnt == s.wd_period) && !comm_pulse) |=> s.flags[`SSFS_F_NET])
    else $error("network flag missing after watchdog expiry");

  a_net_traffic: assert property (@(posedge clk_sys) disable iff (!rst_n)
    comm_pulse |=> !s.flags[`SSFS_F_NET] ##1 (s.wd_cnt == 16'h0000 || s.wd_cnt == 16'h0001))
    else $error("network flag or watchdog not restarted by traffic");

  // an AND function with a low source gives low
  a_logic_and: assert property (@(posedge clk_sys) disable iff (!rst_n)
    ((s.lcfg[0][`SSFS_LC_OP] == `SSFS_OP_AND) && !s.flags[`SSFS_F_MO_B]
     && (s.lcfg[0][`SSFS_LC_SRC_B] == 4'(`SSFS_F_MO_B))) |=> !s.flags[`SSFS_F_LOG_A])
    else $error("logic function a high with a low input");

  // life warnings follow the pins through the synchroniser
  a_cap_life: assert property (@(posedge clk_sys) disable iff (!rst_n)
    capacitor_life_expired [*4] |-> s.flags[`SSFS_F_CAP])
    else $error("capacitor warning not on after expiry");

  a_fan_life: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !cooling_fan_life_expired [*4] |-> !s.flags[`SSFS_F_FAN])
    else $error("fan warning on without expiry");

  // start contact is exclusive or of the commands
  a_start_contact: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s.sync2[`SSFS_P_FWD] && s.sync2[`SSFS_P_REV]) |=> !s.flags[`SSFS_F_START])
    else $error("start contact on with both commands");

  a_start_one: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (s.sync2[`SSFS_P_FWD] != s.sync2[`SSFS_P_REV]) |=> s.flags[`SSFS_F_START])
    else $error("start contact off with one command");

  // measured values against their thresholds, both directions
  a_heat_warn: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (heatsink_temp > s.heat_thr) |=> s.flags[`SSFS_F_HEAT])
    else $error("overheat warning missing");

  a_heat_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (heatsink_temp <= s.heat_thr) |=> !s.flags[`SSFS_F_HEAT])
    else $error("overheat warning on at or below threshold");

  a_low_load: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (motor_current >= s.load_lvl) |=> !s.flags[`SSFS_F_LOAD])
    else $error("low load flag on with enough current");

  a_load_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (motor_current < s.load_lvl) |=> s.flags[`SSFS_F_LOAD])
    else $error("low load flag missing with low current");

  // general output flags follow the software bits one cycle later
  a_gpo_flags: assert property (@(posedge clk_sys) disable iff (!rst_n)
    1'b1 |=> (s.flags[`SSFS_F_MO_B:`SSFS_F_MO_A] == $past(s.gpo)))
    else $error("general output flags do not follow the register");

  // the bus answers in the first access cycle, with an error for unmapped addresses
  a_apb_ready: assert property (@(posedge clk_sys) disable iff (!rst_n)
    setup |=> (pready && (pslverr == $past(!mapped))))
    else $error("bus answer missing or error flag wrong");

  // the answer stands for one cycle only
  a_apb_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
    pready |=> !pready)
    else $error("bus ready held longer than one cycle");

  // reset leaves every flag cleared
  a_reset_clear: assert property (@(posedge clk_sys)
    !rst_n |=> (s.flags == '0))
    else $error("flags not cleared by reset");

endmodule
`default_nettype wire

// [test/ssfs_relay_model.sv]
// relay input model: the external equipment that reads the output terminals
// assumes terminal levels change on clk_sys and a relay coil settles within one cycle
`timescale 1ns/1ps
`default_nettype none

module ssfs_relay_model
#(
  parameter int NUM_TERM = 2
)
(
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // terminals from the block
  input  wire logic [NUM_TERM-1:0] term_out,
  // contact state seen by the controller
  output logic      [NUM_TERM-1:0] contact_ff
);
  // contacts follow the terminal levels one cycle later, open during reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      contact_ff <= '0;
    else
      contact_ff <= term_out;
  end
endmodule
`default_nettype wire

// [test/ssfs_top_test.sv]
// self-checking bench of the status output function selector
// assumes a 25 MHz clk_sys, apb register map of ssfs_defs.svh and a short watchdog tick
`timescale 1ns/1ps
`default_nettype none
`include "ssfs_defs.svh"
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("FAIL %s expected %h seen %h", nm, e, g); end end

module ssfs_top_test;
  import ssfs_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        run = 1'b0;
  logic        fwd = 1'b0;
  logic        rev = 1'b0;
  logic        cap = 1'b0;
  logic        fan = 1'b0;
  logic        comm = 1'b0;
  logic [15:0] fb_val = 16'h0;
  logic [15:0] heat = 16'h0;
  logic [15:0] cur = 16'h0;
  logic [1:0]  term_out;
  logic [1:0]  contact;
  logic        irq;
  logic [31:0] rd;
  logic        er;
  int          failures = 0;
  int          num_checks = 0;

  // 40 ns clock
  always #20 clk_sys = ~clk_sys;

  ssfs_top #(.NUM_TERM(2), .WD_TICK_CYC(16'h0004)) i_ssfs_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_state_in(run), .forward_run_command(fwd), .reverse_run_command(rev),
    .capacitor_life_expired(cap), .cooling_fan_life_expired(fan), .comm_activity(comm),
    .process_feedback_value(fb_val), .heatsink_temp(heat), .motor_current(cur),
    .term_out(term_out), .irq(irq));

  ssfs_relay_model #(.NUM_TERM(2)) i_ssfs_relay_model (
    .clk_sys(clk_sys), .rst_n(rst_n), .term_out(term_out), .contact_ff(contact));

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // one apb transfer; waits for pready, a hang is ended by the watchdog
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // read the flag register and compare one bit
  task automatic fl(input int i, input logic e);
    apb(1'b0, `SSFS_REG_FLAGS, 32'h0);
    `CHK("flag bit", e, rd[i])
  endtask

  task automatic t_reset_regs();
    apb(1'b0, `SSFS_REG_TERM_SEL, 32'h0);
    `CHK("term sel reset", 32'hFFFFFFFF, rd)
    apb(1'b0, `SSFS_REG_FLAGS, 32'h0);
    `CHK("flags reset", 32'h00000000, rd)
    `CHK("terminals reset", 2'b00, term_out)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped error", 1'b1, er)
    `CHK("unmapped data", 32'h00000000, rd)
    apb(1'b1, `SSFS_REG_FB_LOW, 32'hFFFF0064);
    apb(1'b0, `SSFS_REG_FB_LOW, 32'h0);
    `CHK("low limit", 32'h00000064, rd)
    apb(1'b1, `SSFS_REG_FB_HIGH, 32'h000000C8);
  endtask

  // feedback flag: set on run with low feedback, hysteresis, clear on high or stop
  task automatic t_feedback();
    fb_val <= 16'h0032;
    tick(4);
    fl(`SSFS_F_FB2, 1'b0);
    run <= 1'b1;
    tick(4);
    fl(`SSFS_F_FB2, 1'b1);
    fb_val <= 16'h00C8;
    tick(2);
    fl(`SSFS_F_FB2, 1'b1);
    fb_val <= 16'h00C9;
    tick(2);
    fl(`SSFS_F_FB2, 1'b0);
    fb_val <= 16'h0032;
    tick(2);
    fl(`SSFS_F_FB2, 1'b1);
    run <= 1'b0;
    tick(4);
    fl(`SSFS_F_FB2, 1'b0);
  endtask

  // watchdog of three ticks of four cycles
  task automatic t_watchdog();
    fl(`SSFS_F_NET, 1'b0);
    apb(1'b1, `SSFS_REG_WD_PERIOD, 32'h00000003);
    tick(20);
    fl(`SSFS_F_NET, 1'b1);
    comm <= 1'b1;
    tick(4);
    fl(`SSFS_F_NET, 1'b0);
    comm <= 1'b0;
  endtask

  // every operator of the logic functions on the two general outputs
  task automatic t_logic();
    logic [1:0] op;
    apb(1'b1, `SSFS_REG_GPO, 32'h00000001);
    fl(`SSFS_F_MO_A, 1'b1);
    fl(`SSFS_F_MO_B, 1'b0);
    for (int k = 0; k < 4; k++)
    begin
      op = 2'(k);
      apb(1'b1, `SSFS_REG_LOGIC_A, {22'h0, op, 8'hBA});
      apb(1'b1, `SSFS_REG_LOGIC_B, {22'h0, op, 8'hBA});
      apb(1'b1, `SSFS_REG_LOGIC_C, {22'h0, op, 8'hBA});
      tick(2);
      fl(`SSFS_F_LOG_A, (k != 0));
      fl(`SSFS_F_LOG_B, (k != 0));
      fl(`SSFS_F_LOG_C, (k != 0));
    end
    apb(1'b1, `SSFS_REG_GPO, 32'h00000003);
    tick(2);
    fl(`SSFS_F_LOG_C, 1'b0);
  endtask

  // pin driven flags and compared measurements at their boundaries
  task automatic t_pins_values();
    logic [1:0] c;
    cap <= 1'b1;
    tick(4);
    fl(`SSFS_F_CAP, 1'b1);
    fl(`SSFS_F_FAN, 1'b0);
    fan <= 1'b1;
    tick(4);
    fl(`SSFS_F_FAN, 1'b1);
    fan <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      c = 2'(k);
      fwd <= c[0];
      rev <= c[1];
      tick(4);
      fl(`SSFS_F_START, c[0] ^ c[1]);
    end
    apb(1'b1, `SSFS_REG_HEAT_THR, 32'h000003E8);
    apb(1'b1, `SSFS_REG_LOAD_LVL, 32'h0000012C);
    heat <= 16'h03E8;
    cur <= 16'h012C;
    tick(2);
    fl(`SSFS_F_HEAT, 1'b0);
    fl(`SSFS_F_LOAD, 1'b0);
    heat <= 16'h03E9;
    cur <= 16'h012B;
    tick(2);
    fl(`SSFS_F_HEAT, 1'b1);
    fl(`SSFS_F_LOAD, 1'b1);
  endtask

  // each code routed to terminal 0, terminal 1 parked on general output b
  task automatic t_mux();
    logic [7:0] codes [13];
    logic       exp [13];
    apb(1'b1, `SSFS_REG_GPO, 32'h00000001);
    heat <= 16'h0000;
    fwd <= 1'b1;
    rev <= 1'b0;
    codes = '{8'h1F, 8'h20, 8'h21, 8'h22, 8'h23, 8'h27, 8'h28, 8'h29, 8'h2A, 8'h2B, 8'h2C, 8'h2D, 8'h30};
    exp = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0};
    tick(4);
    for (int k = 0; k < 13; k++)
    begin
      apb(1'b1, `SSFS_REG_TERM_SEL, {16'h0, `SSFS_OPT_MO_B, codes[k]});
      tick(3);
      `CHK("terminal 0", exp[k], contact[0])
      `CHK("terminal 1", 1'b0, contact[1])
    end
    apb(1'b1, `SSFS_REG_GPO, 32'h00000002);
    tick(4);
    `CHK("terminal 1 set", 1'b1, contact[1])
  endtask

  // masked and unmasked events, read clear of the status
  task automatic t_irq();
    cur <= 16'h03E8;
    tick(2);
    apb(1'b0, `SSFS_REG_IRQ_ST, 32'h0);
    apb(1'b1, `SSFS_REG_IRQ_MASK, 32'h00000200);
    fan <= 1'b1;
    tick(4);
    `CHK("irq masked", 1'b0, irq)
    cur <= 16'h000A;
    tick(3);
    `CHK("irq raised", 1'b1, irq)
    apb(1'b0, `SSFS_REG_IRQ_ST, 32'h0);
    `CHK("status load", 1'b1, rd[`SSFS_F_LOAD])
    `CHK("status fan", 1'b1, rd[`SSFS_F_FAN])
    tick(2);
    `CHK("irq cleared", 1'b0, irq)
    apb(1'b0, `SSFS_REG_IRQ_ST, 32'h0);
    `CHK("status empty", 32'h00000000, rd)
  endtask

  // counts, verdict and end of run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    #2000000;
    failures++;
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    t_reset_regs();
    t_feedback();
    t_watchdog();
    t_logic();
    t_pins_values();
    t_mux();
    t_irq();
    end_sim();
  end
endmodule
`default_nettype wire
